// [hw/dtlb_mgmt.v]
// Data TLB management registers and data-stream fault capture
// Function
// - Page size hint selects mapping size: two in instr, four in data TLB; here hints 00, 01 and 10 all map as 8 KB, only 11 as large.
// - Two-size case: hint 11 selects large page, else 8 KB.
// - Page size hint governs writes of TLB entries; entry reads do not use it.
// - Data TLB has 32 entries; writes target a not-recently-used entry.
// - Memory unit control bit 9 selects rotating replacement instead.
// - Entry writes use page table layout; some fields ignored, no valid bit.
// - Entry port write loads that entry's tag from the tag staging value.
// - Entry read is two steps: port read fills hold, hold read returns it.
// - Every entry port read advances the entry pointer; every write sets it one past the entry written.
// - Data-stream fault details are captured into fault status.
// - Fault status and address freeze until fault address is read.
// - Status changes only while unlocked on fault or miss.
// - After reset both capture registers are unlocked.
// - Status bit 0 flags store, bit 1 flags access violation.
// - Bit 2 load-fault flag hit, bit 3 store-fault flag hit.
// - Opcode captured in bits 14:9, destination register in 8:4.
// - Fault or miss latches effective virtual address.
// - Clear-all invalidates all 32 entries and resets the pointer.
// - Clear-nonglobal invalidates entries with global bit zero.
// - Clear-one invalidates the entry whose full 30-bit tag equals the given address tag, whatever its page size.
// - Icache clear-all flushes the whole instruction cache.
// - Icache clear-nonglobal invalidates non-global blocks.
`timescale 1ns/1ps
`include "dtlb_mgmt_regs.vh"
module dtlb_mgmt #(
	parameter ENTRIES = 32,
	parameter PW      = 5,
	parameter TAGW    = 30
)(
	input  wire        mclk,
	input  wire        rst_n,
	input  wire        ipr_wr,
	input  wire        ipr_rd,
	input  wire [3:0]  ipr_sel,
	input  wire [63:0] ipr_wdata,
	input  wire [63:0] tag_staging,
	input  wire        flt_event,
	input  wire        flt_miss,
	input  wire        flt_store,
	input  wire        flt_acv,
	input  wire        flt_for,
	input  wire        flt_fow,
	input  wire [5:0]  flt_opcode,
	input  wire [4:0]  flt_ra,
	input  wire [63:0] flt_va,
	input  wire        lookup_req,
	input  wire [TAGW-1:0] lookup_tag,
	output reg  [63:0] ipr_rdata,
	output reg         lookup_hit,
	output reg  [20:0] lookup_frame,
	output reg         lookup_large,
	output reg         ic_flush_all,
	output reg         ic_flush_nonglobal,
	output reg  [1:0]  page_size_hint
);
	reg                rs1_q;
	reg                rs_q;
	reg [TAGW-1:0]     tag_q   [0:ENTRIES-1];
	reg [20:0]         frame_q [0:ENTRIES-1];
	reg [7:0]          perm_q  [0:ENTRIES-1];
	reg [1:0]          flt_q   [0:ENTRIES-1];
	reg [1:0]          size_q  [0:ENTRIES-1];
	reg [ENTRIES-1:0]  valid_q;
	reg [ENTRIES-1:0]  glob_q;
	wire [ENTRIES-1:0] hit_vec;
	wire [ENTRIES-1:0] clr_vec;
	reg [PW-1:0]       ptr_q;
	reg [PW-1:0]       rr_q;
	reg [PW-1:0]       last_q;
	reg [PW-1:0]       victim;
	reg [PW-1:0]       hit_idx;
	reg [PW-1:0]       clr_idx;
	reg                any_hit;
	reg                clr_hit;
	reg [63:0]         hold_q;
	reg                rr_mode_q;
	reg [14:0]         fstat_q;
	reg [63:0]         fva_q;
	reg                lock_q;
	integer            i;
	genvar             g;

	wire [PW:0] ptr_inc  = {1'b0, ptr_q} + {{PW{1'b0}}, 1'b1};
	wire [PW:0] vic_inc  = {1'b0, victim} + {{PW{1'b0}}, 1'b1};
	wire [PW:0] rr_inc   = {1'b0, rr_q} + {{PW{1'b0}}, 1'b1};
	wire        wr_port  = ipr_wr && ipr_sel == `SEL_ENTRY_PORT;
	wire        rd_port  = ipr_rd && ipr_sel == `SEL_ENTRY_PORT;
	wire        rd_fva   = ipr_rd && ipr_sel == `SEL_FAULT_ADDR;
	wire        clr_all  = ipr_wr && ipr_sel == `SEL_CLEAR_ALL;
	wire        clr_ng   = ipr_wr && ipr_sel == `SEL_CLEAR_NONGLOBAL;
	wire        clr_one  = ipr_wr && ipr_sel == `SEL_CLEAR_ONE;
	wire        wr_hint  = ipr_wr && ipr_sel == `SEL_PAGE_SIZE_CTL;
	wire        wr_mu    = ipr_wr && ipr_sel == `SEL_MEM_UNIT_CTL;
	wire        wr_icall = ipr_wr && ipr_sel == `SEL_IC_CLEAR_ALL;
	wire        wr_icng  = ipr_wr && ipr_sel == `SEL_IC_CLEAR_NONGLOB;
	wire        capture  = !lock_q && (flt_event || flt_miss);

	// Reset release through two flops
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rs1_q <= 1'b0;
			rs_q  <= 1'b0;
		end
		else
		begin
			rs1_q <= 1'b1;
			rs_q  <= rs1_q;
		end
	end

	generate
		for (g = 0; g < ENTRIES; g = g + 1)
		begin : g_ent
			assign hit_vec[g] = valid_q[g] &&
				(size_q[g] == `PSH_LARGE ?
				tag_q[g][TAGW-1:9] == lookup_tag[TAGW-1:9] :
				tag_q[g] == lookup_tag);
			assign clr_vec[g] = valid_q[g] &&
				tag_q[g] == ipr_wdata[TAGW+12:13];
		end
	endgenerate

	// Hit and clear index encode
	always @*
	begin
		hit_idx = {PW{1'b0}};
		any_hit = 1'b0;
		clr_idx = {PW{1'b0}};
		clr_hit = 1'b0;
		for (i = 0; i < ENTRIES; i = i + 1)
		begin
			if (hit_vec[i])
			begin
				hit_idx = i[PW-1:0];
				any_hit = 1'b1;
			end
			if (clr_vec[i])
			begin
				clr_idx = i[PW-1:0];
				clr_hit = 1'b1;
			end
		end
	end

	always @*
	begin
		if (ptr_q == last_q)
			victim = ptr_inc[PW-1:0];
		else
			victim = ptr_q;
		if (rr_mode_q)
			victim = rr_q;
	end

	always @(posedge mclk or negedge rs_q)
	begin
		if (!rs_q)
		begin
			page_size_hint <= 2'h0;
			rr_mode_q      <= 1'b0;
		end
		else
		begin
			if (wr_hint)
				page_size_hint <= ipr_wdata[`PSH_HI:`PSH_LO];
			if (wr_mu)
				rr_mode_q <= ipr_wdata[`RR_SEL_BIT];
		end
	end

	// Icache flush pulses
	always @(posedge mclk or negedge rs_q)
	begin
		if (!rs_q)
		begin
			ic_flush_all       <= 1'b0;
			ic_flush_nonglobal <= 1'b0;
		end
		else
		begin
			ic_flush_all       <= wr_icall;
			ic_flush_nonglobal <= wr_icng;
		end
	end

	// lookup result and large page flag
	always @(posedge mclk or negedge rs_q)
	begin
		if (!rs_q)
		begin
			lookup_hit   <= 1'b0;
			lookup_frame <= 21'h000000;
			lookup_large <= 1'b0;
		end
		else
		begin
			lookup_hit   <= lookup_req && any_hit;
			lookup_frame <= frame_q[hit_idx];
			lookup_large <= size_q[hit_idx] == `PSH_LARGE;
		end
	end

	always @(posedge mclk)
	begin
		if (wr_port)
		begin
			tag_q[victim]   <= tag_staging[TAGW+12:13];
			frame_q[victim] <= ipr_wdata[`WR_FRAME_HI:`WR_FRAME_LO];
			perm_q[victim]  <= {ipr_wdata[`WR_RE_HI:`WR_RE_LO],
				ipr_wdata[`WR_WE_HI:`WR_WE_LO]};
			flt_q[victim]   <= {ipr_wdata[`WR_FOW], ipr_wdata[`WR_FOR]};
			size_q[victim]  <= page_size_hint;
		end
	end

	// Entry valid and global bits
	always @(posedge mclk or negedge rs_q)
	begin
		if (!rs_q)
		begin
			valid_q <= {ENTRIES{1'b0}};
			glob_q  <= {ENTRIES{1'b0}};
		end
		else if (clr_all)
			valid_q <= {ENTRIES{1'b0}};
		else
		begin
			if (wr_port)
			begin
				valid_q[victim] <= 1'b1;
				glob_q[victim]  <= ipr_wdata[`WR_GLOBAL];
			end
			if (clr_ng)
				valid_q <= valid_q & glob_q;
			if (clr_one && clr_hit)
				valid_q[clr_idx] <= 1'b0;
		end
	end

	// Entry pointer, rotation and last used
	always @(posedge mclk or negedge rs_q)
	begin
		if (!rs_q)
		begin
			ptr_q  <= `PTR_RESET;
			rr_q   <= `PTR_RESET;
			last_q <= `PTR_RESET;
		end
		else if (clr_all)
		begin
			ptr_q  <= `PTR_RESET;
			rr_q   <= `PTR_RESET;
			last_q <= `PTR_RESET;
		end
		else
		begin
			if (lookup_req && any_hit)
				last_q <= hit_idx;
			if (wr_port)
				last_q <= victim;
			if (wr_port)
				ptr_q <= vic_inc[PW-1:0];
			else if (rd_port)
				ptr_q <= ptr_inc[PW-1:0];
			if (wr_port && rr_mode_q)
				rr_q <= rr_inc[PW-1:0];
		end
	end

	always @(posedge mclk or negedge rs_q)
	begin
		if (!rs_q)
			hold_q <= 64'h0000000000000000;
		else if (rd_port)
			hold_q <= {29'h00000000, glob_q[ptr_q], frame_q[ptr_q],
				perm_q[ptr_q], flt_q[ptr_q], 3'h0};
	end

	always @(posedge mclk or negedge rs_q)
	begin
		if (!rs_q)
		begin
			fstat_q <= 15'h0000;
			fva_q   <= 64'h0000000000000000;
		end
		else if (capture)
		begin
			fstat_q[`FS_STORE] <= flt_store;
			fstat_q[`FS_ACV]   <= flt_acv;
			fstat_q[`FS_FOR]   <= flt_for && !flt_store;
			fstat_q[`FS_FOW]   <= flt_fow && flt_store;
			fstat_q[`FS_RA_LO+4:`FS_RA_LO] <= flt_ra;
			fstat_q[`FS_OP_LO+5:`FS_OP_LO] <= flt_opcode;
			fva_q <= flt_va;
		end
	end

	always @(posedge mclk or negedge rs_q)
	begin
		if (!rs_q)
			lock_q <= 1'b0;
		else if (capture)
			lock_q <= 1'b1;
		else if (rd_fva)
			lock_q <= 1'b0;
	end

	// Read data one cycle after select
	always @(posedge mclk or negedge rs_q)
	begin
		if (!rs_q)
			ipr_rdata <= 64'h0000000000000000;
		else
		begin
			case (ipr_sel)
				`SEL_READ_HOLD:    ipr_rdata <= hold_q;
				`SEL_FAULT_STATUS: ipr_rdata <= {49'h0, fstat_q};
				`SEL_FAULT_ADDR:   ipr_rdata <= fva_q;
				default:           ipr_rdata <= 64'h0000000000000000;
			endcase
		end
	end
endmodule

// [inc/dtlb_mgmt_regs.vh]
// Register selects, field positions and reset values of the data TLB block
`ifndef DTLB_MGMT_REGS_VH
`define DTLB_MGMT_REGS_VH
`define SEL_PAGE_SIZE_CTL     4'h0
`define SEL_ENTRY_PORT        4'h1
`define SEL_READ_HOLD         4'h2
`define SEL_FAULT_STATUS      4'h3
`define SEL_FAULT_ADDR        4'h4
`define SEL_CLEAR_ALL         4'h5
`define SEL_CLEAR_NONGLOBAL   4'h6
`define SEL_CLEAR_ONE         4'h7
`define SEL_IC_CLEAR_ALL      4'h8
`define SEL_IC_CLEAR_NONGLOB  4'h9
`define SEL_MEM_UNIT_CTL      4'hA
`define PSH_HI                6
`define PSH_LO                5
`define PSH_LARGE             2'h3
`define RR_SEL_BIT            9
`define WR_FRAME_HI           52
`define WR_FRAME_LO           32
`define WR_WE_HI              15
`define WR_WE_LO              12
`define WR_RE_HI              11
`define WR_RE_LO              8
`define WR_GLOBAL             4
`define WR_FOW                2
`define WR_FOR                1
`define HOLD_GLOBAL           34
`define FS_STORE              0
`define FS_ACV                1
`define FS_FOR                2
`define FS_FOW                3
`define FS_RA_LO              4
`define FS_OP_LO              9
`define PTR_RESET             5'h00
`endif

// [verif/dtlb_mgmt_checker.sv]
// Assertion checker for the data TLB management block
`timescale 1ns/1ps
`include "dtlb_mgmt_regs.vh"
module dtlb_mgmt_checker (
	input wire        mclk, rst_n, ipr_wr, ipr_rd, flt_event, flt_miss,
	input wire        lookup_req, lookup_hit, ic_flush_all, ic_flush_nonglobal,
	input wire [3:0]  ipr_sel,
	input wire [63:0] ipr_wdata, flt_va, ipr_rdata,
	input wire [1:0]  page_size_hint
);
	reg        lock_q;
	reg [63:0] va_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	always @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			lock_q <= 1'h0;
			va_q <= 64'h0;
		end
		else if ((flt_event || flt_miss) && !lock_q)
		begin
			lock_q <= 1'h1;
			va_q <= flt_va;
		end
		else if (ipr_rd && ipr_sel == `SEL_FAULT_ADDR)
			lock_q <= 1'h0;
	sequence s_va_rd;
		ipr_rd && ipr_sel == `SEL_FAULT_ADDR && !flt_event && !flt_miss;
	endsequence
	sequence s_hint_wr;
		ipr_wr && ipr_sel == `SEL_PAGE_SIZE_CTL;
	endsequence
	a_va_locked: assert property (s_va_rd |=> ipr_rdata == va_q)
		else $error("fault address read mismatch");
	a_hint_write: assert property (s_hint_wr |=>
		page_size_hint == $past(ipr_wdata[6:5])) else $error("hint not taken");
	a_hint_hold: assert property (!(ipr_wr &&
		ipr_sel == `SEL_PAGE_SIZE_CTL) |=>
		$stable(page_size_hint)) else $error("hint changed unasked");
	a_icall_pulse: assert property (ipr_wr &&
		ipr_sel == `SEL_IC_CLEAR_ALL |=> ic_flush_all) else $error("no flush");
	a_icall_cause: assert property (ic_flush_all |->
		$past(ipr_wr && ipr_sel == `SEL_IC_CLEAR_ALL)) else $error("stray flush");
	a_icng_pulse: assert property (ipr_wr &&
		ipr_sel == `SEL_IC_CLEAR_NONGLOB |=> ic_flush_nonglobal)
		else $error("no nonglobal flush");
	a_hit_cause: assert property (lookup_hit |-> $past(lookup_req))
		else $error("hit without request");
	a_unmapped_zero: assert property (ipr_rd &&
		ipr_sel > `SEL_MEM_UNIT_CTL |=> ipr_rdata == 64'h0)
		else $error("unmapped read not zero");
endmodule
bind dtlb_mgmt dtlb_mgmt_checker chk (
	.mclk(mclk), .rst_n(rst_n), .ipr_wr(ipr_wr), .ipr_rd(ipr_rd),
	.flt_event(flt_event), .flt_miss(flt_miss), .lookup_req(lookup_req),
	.lookup_hit(lookup_hit), .ic_flush_all(ic_flush_all),
	.ic_flush_nonglobal(ic_flush_nonglobal), .ipr_sel(ipr_sel),
	.ipr_wdata(ipr_wdata), .flt_va(flt_va), .ipr_rdata(ipr_rdata),
	.page_size_hint(page_size_hint));

// [verif/tb_dtlb_mgmt.sv]
// Self-checking bench for the data TLB management block
`timescale 1ns/1ps
`include "dtlb_mgmt_regs.vh"
module tb_dtlb_mgmt;
	reg         mclk = '0, rst_n = '0, ipr_wr = '0, ipr_rd = '0;
	reg         flt_event = '0, flt_miss = '0, flt_store = '0, lookup_req = '0;
	reg         flt_acv = '0;
	reg  [3:0]  ipr_sel = '0;
	reg  [63:0] ipr_wdata = '0, tag_staging = '0, flt_va = '0, stg = '0;
	reg  [29:0] lookup_tag = '0;
	wire [63:0] ipr_rdata;
	wire [20:0] lookup_frame;
	wire        lookup_hit, lookup_large, ic_flush_all, ic_flush_nonglobal;
	wire [1:0]  page_size_hint;
	integer     n_fail = 0, cmp_count = 0, i;
	always #5 mclk = ~mclk;
	dtlb_mgmt DUT (.mclk(mclk), .rst_n(rst_n), .ipr_wr(ipr_wr),
		.ipr_rd(ipr_rd), .ipr_sel(ipr_sel), .ipr_wdata(ipr_wdata),
		.tag_staging(tag_staging), .flt_event(flt_event), .flt_miss(flt_miss),
		.flt_store(flt_store), .flt_acv(flt_acv), .flt_for(1'h1), .flt_fow(1'h1),
		.flt_opcode(6'h2A), .flt_ra(5'h13), .flt_va(flt_va),
		.lookup_req(lookup_req), .lookup_tag(lookup_tag),
		.ipr_rdata(ipr_rdata), .lookup_hit(lookup_hit),
		.lookup_frame(lookup_frame), .lookup_large(lookup_large),
		.ic_flush_all(ic_flush_all), .ic_flush_nonglobal(ic_flush_nonglobal),
		.page_size_hint(page_size_hint));
	task cmp(input [63:0] got, exp);
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			n_fail = n_fail + 1;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task op(input w, r, input [3:0] s, input [63:0] d);
		@(posedge mclk);
		ipr_wr <= w;
		ipr_rd <= r;
		ipr_sel <= s;
		ipr_wdata <= d;
		tag_staging <= stg;
		@(posedge mclk);
		ipr_wr <= 1'h0;
		ipr_rd <= 1'h0;
		#1;
	endtask
	task lk(input [29:0] t, input h, input [20:0] f);
		@(posedge mclk);
		lookup_req <= 1'h1;
		lookup_tag <= t;
		@(posedge mclk);
		lookup_req <= 1'h0;
		#1;
		cmp(lookup_hit, h);
		if (h)
			cmp(lookup_frame, f);
	endtask
	task flt(input m, st, input [63:0] va);
		@(posedge mclk);
		flt_event <= ~m;
		flt_miss <= m;
		flt_store <= st;
		flt_acv <= m;
		flt_va <= va;
		@(posedge mclk);
		flt_event <= 1'h0;
		flt_miss <= 1'h0;
	endtask
	task finish_test;
		$display("compares %0d failures %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (4) @(posedge mclk);
		for (i = 3; i >= 0; i = i - 1)
		begin
			op(1, 0, `SEL_PAGE_SIZE_CTL, i << 5);
			cmp(page_size_hint, i);
		end
		op(1, 0, `SEL_MEM_UNIT_CTL, 64'h200);
		op(1, 0, `SEL_CLEAR_ALL, 64'h0);
		for (i = 0; i < 32; i = i + 1)
		begin
			stg = (i + 64'h100) << 13;
			op(1, 0, `SEL_ENTRY_PORT, {11'h0, 21'(i + 1), 24'h5A0, 3'h0,
				i[0], 4'h4});
		end
		for (i = 0; i < 2; i = i + 1)
		begin
			op(0, 1, `SEL_ENTRY_PORT, 64'h0);
			op(0, 1, `SEL_READ_HOLD, 64'h0);
			cmp(ipr_rdata, {29'h0, i[0], 21'(i + 1), 13'h0150});
		end
		lk(30'h100, 1, 21'h1);
		op(1, 0, `SEL_CLEAR_NONGLOBAL, 64'h0);
		lk(30'h100, 0, 21'h0);
		lk(30'h101, 1, 21'h2);
		op(1, 0, `SEL_CLEAR_ONE, 64'h202000);
		lk(30'h101, 0, 21'h0);
		lk(30'h103, 1, 21'h4);
		op(1, 0, `SEL_CLEAR_ALL, 64'h0);
		lk(30'h103, 0, 21'h0);
		op(1, 0, `SEL_MEM_UNIT_CTL, 64'h0);
		op(1, 0, `SEL_PAGE_SIZE_CTL, 64'h60);
		stg = 64'h200 << 13;
		op(1, 0, `SEL_ENTRY_PORT, {11'h0, 21'h7, 32'h0});
		lk(30'h3FF, 1, 21'h7);
		cmp(lookup_large, 64'h1);
		op(1, 0, `SEL_IC_CLEAR_ALL, 64'h0);
		cmp(ic_flush_all, 64'h1);
		op(1, 0, `SEL_IC_CLEAR_NONGLOB, 64'h0);
		cmp(ic_flush_nonglobal, 64'h1);
		flt(1, 0, 64'h1111);
		flt(0, 1, 64'h2222);
		op(0, 1, `SEL_FAULT_ADDR, 64'h0);
		cmp(ipr_rdata, 64'h1111);
		flt(0, 1, 64'h3333);
		flt(0, 0, 64'h4444);
		op(0, 1, `SEL_FAULT_STATUS, 64'h0);
		cmp(ipr_rdata, {49'h0, 6'h2A, 5'h13, 4'h9});
		op(0, 1, `SEL_FAULT_ADDR, 64'h0);
		cmp(ipr_rdata, 64'h3333);
		flt(0, 0, 64'h5555);
		op(0, 1, `SEL_FAULT_STATUS, 64'h0);
		cmp(ipr_rdata, {49'h0, 6'h2A, 5'h13, 4'h4});
		op(0, 1, 4'hF, 64'h0);
		cmp(ipr_rdata, 64'h0);
		finish_test;
	end
endmodule
